/* File: rtcc_host_model.sv */
// rtcc_host_model: behavioural serial engine host driving the register
// port of the counter block; the bench calls its byte tasks.
// assumes the block samples every strobe on the rising edge of clk.
`timescale 1ns/1ps
module rtcc_host_model (
  // system clock
  input  wire logic       clk,
  // register port towards the block
  output logic            access_busy,
  output logic [7:0]      reg_addr,
  output logic            reg_we,
  output logic            reg_re,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  // read result towards the bench monitor
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  // idle values at time zero
  initial begin
    access_busy = 1'b0;
    reg_addr    = 8'h00;
    reg_we      = 1'b0;
    reg_re      = 1'b0;
    reg_wdata   = 8'h00;
    rd_valid    = 1'b0;
    rd_data     = 8'h00;
  end

  // busy is a level framing a whole access, so bytes stay consistent
  task automatic frame(input logic v);
    @(posedge clk) #1;
    access_busy = v;
  endtask : frame

  // one byte write; lines inverted afterwards so stale data never helps
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_we    = 1'b1;
    @(posedge clk) #1;
    reg_we    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // one byte read; data taken the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk) #1;
    reg_addr = a;
    reg_re   = 1'b1;
    @(posedge clk) #1;
    reg_re   = 1'b0;
    reg_addr = ~a;
    rd_data  = reg_rdata;
    rd_valid = 1'b1;
    @(posedge clk) #1;
    rd_valid = 1'b0;
  endtask : rd
endmodule : rtcc_host_model

/* File: rtcc_pkg.sv */
// rtcc_pkg: register offsets, field masks, reset values and timing
// constants shared by the time and date counter block.
// assumes a 10 MHz system clock and a crystal-derived link clock.
package rtcc_pkg;

  // register offsets on the register port
  localparam logic [7:0] ADDR_SECONDS = 8'h04;
  localparam logic [7:0] ADDR_MINUTES = 8'h05;
  localparam logic [7:0] ADDR_HOURS   = 8'h06;
  localparam logic [7:0] ADDR_DAYS    = 8'h07;
  localparam logic [7:0] ADDR_WEEKDAY = 8'h08;
  localparam logic [7:0] ADDR_MONTHS  = 8'h09;
  localparam logic [7:0] ADDR_YEARS   = 8'h0a;

  // field masks, unused bits read zero
  localparam logic [7:0] MASK_SECONDS = 8'h7f;
  localparam logic [7:0] MASK_MINUTES = 8'h7f;
  localparam logic [7:0] MASK_HOURS   = 8'h3f;
  localparam logic [7:0] MASK_H12     = 8'h1f;
  localparam logic [7:0] MASK_DAYS    = 8'h3f;
  localparam logic [7:0] MASK_WEEKDAY = 8'h07;
  localparam logic [7:0] MASK_MONTHS  = 8'h1f;
  localparam logic [7:0] MASK_YEARS   = 8'hff;
  localparam int         BIT_OSC_FLAG = 7;
  localparam int         BIT_MERIDIEM = 5;

  // reset values
  localparam logic [7:0] RST_SECONDS = 8'h00;
  localparam logic [7:0] RST_MINUTES = 8'h00;
  localparam logic [7:0] RST_HOURS   = 8'h00;
  localparam logic [7:0] RST_DAYS    = 8'h01;
  localparam logic [7:0] RST_WEEKDAY = 8'h06;
  localparam logic [7:0] RST_MONTHS  = 8'h01;
  localparam logic [7:0] RST_YEARS   = 8'h00;

  // BCD limits used by the carry chain
  localparam logic [7:0] BCD_59    = 8'h59;
  localparam logic [7:0] BCD_23    = 8'h23;
  localparam logic [7:0] BCD_11    = 8'h11;
  localparam logic [7:0] BCD_12    = 8'h12;
  localparam logic [7:0] BCD_99    = 8'h99;
  localparam logic [7:0] BCD_01    = 8'h01;
  localparam logic [7:0] BCD_00    = 8'h00;
  localparam logic [7:0] DOW_LAST  = 8'h06;
  localparam logic [7:0] MON_FEB   = 8'h02;
  localparam logic [7:0] MON_APR   = 8'h04;
  localparam logic [7:0] MON_JUN   = 8'h06;
  localparam logic [7:0] MON_SEP   = 8'h09;
  localparam logic [7:0] MON_NOV   = 8'h11;
  localparam logic [7:0] LEN_28    = 8'h28;
  localparam logic [7:0] LEN_29    = 8'h29;
  localparam logic [7:0] LEN_30    = 8'h30;
  localparam logic [7:0] LEN_31    = 8'h31;

  // timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int OSC_HZ          = 32768;
  localparam int STOP_TIMEOUT_US = 5000;
  localparam int STOP_TIMEOUT_CYC =
    (STOP_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int HB_DIV          = 64;
  localparam int STABLE_BEATS    = 16;

endpackage : rtcc_pkg

/* File: rtcc_time_date.sv */
// rtcc_time_date: BCD time and calendar counters with oscillator stop
// flag, 12/24 hour formatting, leap years and access freeze.
// assumes a serial bus engine drives the register port on clk and holds
// access_busy for a whole transfer; osc_clk is the crystal clock.
//
// Behaviour
// R1: seconds hold BCD tens in bits 6..4, units in bits 3..0, 00-59.
// R2: seconds bit 7 is oscillator stop flag, one means suspect, resets one.
// R3: flag is set whenever the crystal oscillator stops or is interrupted; the code sets it only after STOP_CYC cycles without a heartbeat.
// R4: until the crystal is stable after power-on the flag stays set.
// R5: flag holds until a clearing write; clearing fails while oscillator stopped.
// R6: host may clear and re-read the flag to check oscillator health.
// R7: minutes hold BCD tens bits 6..4, units 3..0, bit 7 reads zero.
// R8: 24 hour hours hold tens bits 5..4, units 3..0, bits 7..6 zero.
// R9: 12 hour mode: bit 5 meridiem, bit 4 tens, bits 3..0 units.
// R10: hour format input selects 12 or 24 hour interpretation.
// R11: days hold BCD tens bits 5..4, units 3..0, upper bits zero, reset 1.
// R12: year divisible by four, including 00, gives February a 29th day.
// R13: weekday is 0 to 6 in bits 2..0, bits 7..3 read zero.
// R14: weekday counts 0 to 6 cyclically, reset value six.
// R15: months hold BCD tens bit 4, units 3..0, 01-12, reset January.
// R16: each 1 Hz tick increments seconds with carries through years.
// R17: 12 hour counts 12,01..11; meridiem toggles at 11 to 12.
// R18: counters freeze during a host access so no carry lands mid-access.
// R19: one tick is held while frozen and applied after release.
// R20: years hold two BCD digits 00-99; leap test uses them.
`timescale 1ns/1ps
module rtcc_time_date
  import rtcc_pkg::*;
#(
  parameter int TICK_DIV     = OSC_HZ,
  parameter int STOP_CYC     = STOP_TIMEOUT_CYC,
  parameter int HB_DIVIDE    = HB_DIV,
  parameter int STABLE_COUNT = STABLE_BEATS
) (
  // system clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // crystal derived link clock
  input  wire logic       osc_clk,
  // register port from the serial engine
  input  wire logic       access_busy,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // configuration and status
  input  wire logic       hour_mode_12,
  output logic            osc_halt_flag
);

  localparam int DIV_W  = $clog2(TICK_DIV);
  localparam int HB_W   = $clog2(HB_DIVIDE);
  localparam int STOP_W = $clog2(STOP_CYC + 1);
  localparam int BEAT_W = $clog2(STABLE_COUNT + 1);
  localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(TICK_DIV - 1);
  localparam logic [HB_W-1:0]   HB_LAST   = HB_W'(HB_DIVIDE - 1);
  localparam logic [STOP_W-1:0] STOP_LAST = STOP_W'(STOP_CYC);
  localparam logic [BEAT_W-1:0] BEAT_LAST = BEAT_W'(STABLE_COUNT);

  // ---------------- link domain ----------------
  logic             orst_m, orst_q;
  logic [DIV_W-1:0] div_q;
  logic [HB_W-1:0]  hb_q;
  logic             tick_tgl_q, hb_tgl_q;

  // reset level brought into the crystal domain
  always_ff @(posedge osc_clk) begin
    orst_m <= sys_rst;
    orst_q <= orst_m;
  end

  // 1 Hz divider, toggles once per second
  always_ff @(posedge osc_clk) begin
    if (orst_q) begin
      div_q      <= '0;
      tick_tgl_q <= 1'b0;
    end else if (div_q == DIV_LAST) begin
      div_q      <= '0;
      tick_tgl_q <= ~tick_tgl_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // heartbeat slow enough for clk to see every toggle
  always_ff @(posedge osc_clk) begin
    if (orst_q) begin
      hb_q     <= '0;
      hb_tgl_q <= 1'b0;
    end else if (hb_q == HB_LAST) begin
      hb_q     <= '0;
      hb_tgl_q <= ~hb_tgl_q;
    end else begin
      hb_q <= hb_q + 1'b1;
    end
  end

  // ---------------- system domain ----------------
  logic t_m, t_s, t_p, h_m, h_s, h_p;
  logic tick_evt, hb_evt;

  // toggle synchronisers, first stage read only by the second; cleared
  // in reset so a short reset cannot leak an unknown edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {t_m, t_s, t_p, h_m, h_s, h_p} <= '0;
    end else begin
      t_m <= tick_tgl_q;
      t_s <= t_m;
      t_p <= t_s;
      h_m <= hb_tgl_q;
      h_s <= h_m;
      h_p <= h_s;
    end
  end
  assign tick_evt = t_s ^ t_p;
  assign hb_evt   = h_s ^ h_p;

  logic [STOP_W-1:0] idle_q;
  logic [BEAT_W-1:0] beats_q;
  logic              osc_run_q;

  // stop watchdog: no heartbeat for STOP_CYC cycles means stopped
  always_ff @(posedge clk) begin
    if (sys_rst || hb_evt) begin
      idle_q <= '0;
    end else if (idle_q != STOP_LAST) begin
      idle_q <= idle_q + 1'b1;
    end
  end

  // stable only after enough beats since start or since a stop
  always_ff @(posedge clk) begin
    if (sys_rst || idle_q == STOP_LAST) begin
      beats_q <= '0; // R4
    end else if (hb_evt && beats_q != BEAT_LAST) begin
      beats_q <= beats_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_run_q <= 1'b0;
    end else begin
      osc_run_q <= (beats_q == BEAT_LAST) && (idle_q != STOP_LAST); // R3
    end
  end

  // ---------------- counters ----------------
  logic [6:0] sec_q;
  logic [7:0] min_q, hour_q, day_q, dow_q, mon_q, year_q;
  logic       osc_flag_q, pend_q, apply;
  logic       wr_sec, wr_min, wr_hour, wr_day, wr_dow, wr_mon, wr_year;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // BCD year divisible by four: even tens with 0/4/8 or odd tens with 2/6
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction : is_leap

  function automatic logic [7:0] month_len(input logic [7:0] m,
                                           input logic [7:0] y);
    case (m)
      MON_FEB: month_len = is_leap(y) ? LEN_29 : LEN_28; // R12
      MON_APR, MON_JUN, MON_SEP, MON_NOV: month_len = LEN_30;
      default: month_len = LEN_31;
    endcase
  endfunction : month_len

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  assign wr_sec  = reg_we && hit(reg_addr, ADDR_SECONDS);
  assign wr_min  = reg_we && hit(reg_addr, ADDR_MINUTES);
  assign wr_hour = reg_we && hit(reg_addr, ADDR_HOURS);
  assign wr_day  = reg_we && hit(reg_addr, ADDR_DAYS);
  assign wr_dow  = reg_we && hit(reg_addr, ADDR_WEEKDAY);
  assign wr_mon  = reg_we && hit(reg_addr, ADDR_MONTHS);
  assign wr_year = reg_we && hit(reg_addr, ADDR_YEARS);

  // held tick is applied only outside an access and outside a write
  assign apply = pend_q && !access_busy && !reg_we; // R18

  // one pending tick; a new tick in the apply cycle is kept
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= tick_evt || (pend_q && !apply); // R19
    end
  end

  // carry chain, all next values from the current state
  logic [7:0] sec_n, min_n, hour_n, day_n, dow_n, mon_n, year_n;
  logic       c_min, c_hour, c_day, c_mon, c_year, h12_last;
  assign c_min    = ({1'b0, sec_q} == BCD_59); // R16
  assign c_hour   = c_min && (min_q == BCD_59);
  assign h12_last = ((hour_q & MASK_H12) == BCD_11);
  // 12 hour: the day moves on only from PM 11; 24 hour: from 23
  assign c_day    = c_hour && (hour_mode_12 ? // R10
                    (h12_last && hour_q[BIT_MERIDIEM]) : (hour_q == BCD_23));
  assign c_mon    = c_day && (day_q == month_len(mon_q, year_q)); // R11
  assign c_year   = c_mon && (mon_q == BCD_12); // R15
  always_comb begin
    sec_n  = c_min ? BCD_00 : bcd_inc({1'b0, sec_q});
    min_n  = min_q;
    hour_n = hour_q;
    day_n  = day_q;
    dow_n  = dow_q;
    mon_n  = mon_q;
    year_n = year_q;
    if (c_min) begin
      min_n = c_hour ? BCD_00 : bcd_inc(min_q);
    end
    if (c_hour) begin
      if (hour_mode_12 && h12_last) begin
        hour_n = {2'b00, ~hour_q[BIT_MERIDIEM], BCD_12[4:0]}; // R17
      end else if (hour_mode_12 && (hour_q & MASK_H12) == BCD_12) begin
        hour_n = {2'b00, hour_q[BIT_MERIDIEM], BCD_01[4:0]}; // R9
      end else if (c_day) begin
        hour_n = BCD_00; // R8
      end else begin
        hour_n = bcd_inc(hour_q);
      end
    end
    if (c_day) begin
      dow_n = (dow_q == DOW_LAST) ? BCD_00 : dow_q + 8'h01; // R14
      day_n = c_mon ? BCD_01 : bcd_inc(day_q);
    end
    if (c_mon) begin
      mon_n = c_year ? BCD_01 : bcd_inc(mon_q);
    end
    if (c_year) begin
      year_n = (year_q == BCD_99) ? BCD_00 : bcd_inc(year_q); // R20
    end
  end

  // host writes win over the counter, unused bits are masked off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sec_q <= RST_SECONDS[6:0];
    end else if (wr_sec) begin
      sec_q <= reg_wdata[6:0] & MASK_SECONDS[6:0]; // R1
    end else if (apply) begin
      sec_q <= sec_n[6:0];
    end
  end

  // next value of a counter byte: write first, then a held tick, else hold
  function automatic logic [7:0] upd(input logic       w,
                                     input logic [7:0] m,
                                     input logic [7:0] n,
                                     input logic [7:0] q);
    if (w) begin
      upd = reg_wdata & m;
    end else if (apply) begin
      upd = n;
    end else begin
      upd = q;
    end
  endfunction : upd

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      min_q  <= RST_MINUTES;
      hour_q <= RST_HOURS;
      day_q  <= RST_DAYS;
      dow_q  <= RST_WEEKDAY;
      mon_q  <= RST_MONTHS;
      year_q <= RST_YEARS;
    end else begin
      min_q  <= upd(wr_min, MASK_MINUTES, min_n, min_q); // R7
      hour_q <= upd(wr_hour, MASK_HOURS, hour_n, hour_q); // R8
      day_q  <= upd(wr_day, MASK_DAYS, day_n, day_q); // R11
      dow_q  <= upd(wr_dow, MASK_WEEKDAY, dow_n, dow_q); // R13
      mon_q  <= upd(wr_mon, MASK_MONTHS, mon_n, mon_q); // R15
      year_q <= upd(wr_year, MASK_YEARS, year_n, year_q); // R20
    end
  end

  // stop flag: a stopped oscillator wins over a clearing write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_flag_q <= 1'b1; // R2
    end else if (!osc_run_q) begin
      osc_flag_q <= 1'b1; // R3 R4
    end else if (wr_sec) begin
      osc_flag_q <= reg_wdata[BIT_OSC_FLAG]; // R5
    end
  end
  assign osc_halt_flag = osc_flag_q;

  // registered read data, unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= BCD_00;
    end else if (reg_re) begin
      case (reg_addr)
        ADDR_SECONDS: reg_rdata <= {osc_flag_q, sec_q};
        ADDR_MINUTES: reg_rdata <= min_q;
        ADDR_HOURS:   reg_rdata <= hour_q;
        ADDR_DAYS:    reg_rdata <= day_q;
        ADDR_WEEKDAY: reg_rdata <= dow_q;
        ADDR_MONTHS:  reg_rdata <= mon_q;
        ADDR_YEARS:   reg_rdata <= year_q;
        default:      reg_rdata <= BCD_00;
      endcase
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_flag_reset: assert property ($fell(sys_rst) |-> osc_flag_q) // R2
    else $error("stop flag not set after reset");
  chk_flag_stopped: assert property (!osc_run_q |=> osc_flag_q) // R3
    else $error("stop flag clear while oscillator stopped");
  chk_flag_sticky: assert property (
    (osc_flag_q && !(wr_sec && !reg_wdata[BIT_OSC_FLAG])) |=> osc_flag_q)
    else $error("stop flag dropped without clearing write"); // R5
  chk_freeze_time: assert property ((access_busy && !reg_we) |=>
    $stable({sec_q, min_q, hour_q, day_q, dow_q, mon_q, year_q}))
    else $error("counters moved during access"); // R18
  chk_pend_apply: assert property ((apply && !tick_evt) |=>
    (sec_q != $past(sec_q)) && !pend_q) // R19
    else $error("pending tick not applied");
  chk_sec_range: assert property ((sec_q[3:0] <= 4'h9) &&
    (sec_q[6:4] <= 3'h5) || $past(wr_sec)) // R1
    else $error("seconds out of BCD range");
  chk_unused_zero: assert property ((min_q[7] == 1'b0) &&
    (hour_q[7:6] == 2'b00) && (dow_q[7:3] == 5'h00) &&
    (mon_q[7:5] == 3'h0) && (day_q[7:6] == 2'b00)) // R13
    else $error("unused bits not zero");
  chk_leap_feb: assert property ((apply && c_day && mon_q == MON_FEB &&
    day_q == LEN_28 && is_leap(year_q) && !reg_we) |=> day_q == LEN_29)
    else $error("leap day skipped"); // R12
  chk_meridiem_flip: assert property ((apply && c_hour && hour_mode_12 &&
    (hour_q & MASK_H12) == BCD_11) |=>
    hour_q[BIT_MERIDIEM] != $past(hour_q[BIT_MERIDIEM])) // R17
    else $error("meridiem did not toggle");
  chk_weekday_wrap: assert property ((apply && c_day &&
    dow_q == DOW_LAST) |=> dow_q == BCD_00) // R14
    else $error("weekday did not wrap");

  cov_tick_applied: cover property (apply ##1 !pend_q);
  cov_flag_cleared: cover property (osc_flag_q ##1 !osc_flag_q);
  cov_pm_midnight: cover property (apply && c_day && hour_mode_12);
  cov_year_wrap: cover property (apply && c_year && year_q == BCD_99);

endmodule : rtcc_time_date

/* File: test_rtcc_time_date.sv */
// test_rtcc_time_date: self-checking bench for the time/date counters.
// assumes rtcc_pkg and rtcc_host_model are compiled beforehand.
`timescale 1ns/1ps
module test_rtcc_time_date;
  import rtcc_pkg::*;
  // short second so a run stays small
  localparam int TDIV = 512;
  // stop detection and settling counts scaled to match; heartbeat divider kept at 64
  localparam int TSTOP = 200;
  localparam int THB   = 64;
  localparam int TBEAT = 4;
  // sec min hr day wd mon yr, in and expected after one tick
  localparam logic [55:0] C_IN [11] = '{
    56'h59592328060223, 56'h59592328030224, 56'h59592329030200,
    56'h59592331051299, 56'h59592330010405, 56'h09000915020705,
    56'h59590910020705, 56'h59591110020705, 56'h59593110020705,
    56'h59591210020705, 56'h59592910020705};
  localparam logic [55:0] C_OUT [11] = '{
    56'h00000001000323, 56'h00000029040224, 56'h00000001040300,
    56'h00000001060100, 56'h00000001020505, 56'h10000915020705,
    56'h00001010020705, 56'h00003210020705, 56'h00001211030705,
    56'h00000110020705, 56'h00003010020705};
  localparam logic [10:0] C_MODE = 11'b11110000000;
  localparam logic [7:0] RSTV [7] = '{8'h80 | RST_SECONDS, RST_MINUTES,
    RST_HOURS, RST_DAYS, RST_WEEKDAY, RST_MONTHS, RST_YEARS};
  localparam logic [7:0] MSK [6] = '{MASK_MINUTES, MASK_HOURS,
    MASK_DAYS, MASK_WEEKDAY, MASK_MONTHS, MASK_YEARS};

  logic        clk;
  logic        osc_clk;
  logic        osc_run;
  logic        sys_rst;
  logic        hour_mode_12;
  logic        access_busy;
  logic        reg_we;
  logic        reg_re;
  logic        rd_valid;
  logic        osc_halt_flag;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  rd_data;
  logic [7:0]  exp_q[$];
  logic [31:0] rng;
  logic [7:0]  rv;
  int          miscompares;
  int          checks;

  rtcc_time_date #(.TICK_DIV(TDIV), .STOP_CYC(TSTOP), .HB_DIVIDE(THB),
    .STABLE_COUNT(TBEAT)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .osc_clk(osc_clk), .access_busy(access_busy), .reg_addr(reg_addr),
    .reg_we(reg_we), .reg_re(reg_re), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .hour_mode_12(hour_mode_12),
    .osc_halt_flag(osc_halt_flag));
  rtcc_host_model i_host (.clk(clk), .access_busy(access_busy),
    .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rd_valid(rd_valid),
    .rd_data(rd_data));

  // system clock, 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // crystal stand-in, 6 ns; stands still while stopped
  initial begin
    osc_clk = 1'b0;
    #1.3; // keeps crystal edges off the system clock edges
    forever #3 if (osc_run) osc_clk = ~osc_clk;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic fail(input string s);
    miscompares++;
    $display("mismatch at %0t: %s", $time, s);
  endtask : fail

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e) fail($sformatf("read %h expected %h", got, e));
  endtask : cmp_byte

  task automatic cmp_flag(input logic e);
    checks++;
    if (osc_halt_flag !== e) fail("stop flag wrong");
  endtask : cmp_flag

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask : rd_exp

  // monitor: oldest note against each read result
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) fail("read with no expectation");
      else cmp_byte(rd_data, exp_q.pop_front());
    end
  end

  // hold busy over several ticks, stop crystal, release briefly:
  // exactly one stored tick must land
  task automatic step(input logic [55:0] o);
    repeat (150) @(posedge clk);
    #1 osc_run = 1'b0;
    repeat (5) @(posedge clk);
    i_host.frame(1'b0);
    repeat (6) @(posedge clk);
    i_host.frame(1'b1);
    osc_run = 1'b1;
    for (int k = 0; k < 7; k++) begin
      rd_exp(8'h04 + 8'(k), o[55-8*k -: 8]);
    end
  endtask : step

  task automatic run_case(input logic m, input logic [55:0] i,
                          input logic [55:0] o);
    @(posedge clk) #1 hour_mode_12 = m;
    i_host.frame(1'b1);
    for (int k = 0; k < 7; k++) i_host.wr(8'h04 + 8'(k), i[55-8*k -: 8]);
    step(o);
    i_host.frame(1'b0);
  endtask : run_case

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // watchdog, well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail("watchdog expired");
    end_sim();
  end

  initial begin
    sys_rst      = 1'b1;
    osc_run      = 1'b1;
    hour_mode_12 = 1'b0;
    miscompares  = 0;
    checks       = 0;
    rng          = 32'h93e34153;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    // defaults; clearing before the crystal settles must not stick
    cmp_flag(1'b1);
    i_host.frame(1'b1);
    i_host.wr(ADDR_SECONDS, 8'h00);
    for (int k = 0; k < 7; k++) rd_exp(8'h04 + 8'(k), RSTV[k]);
    i_host.wr(8'h0b, 8'hff);
    rd_exp(8'h0b, 8'h00);
    i_host.frame(1'b0);
    $display("test reset values done");
    repeat (100) @(posedge clk);
    // counting and carries, both hour formats
    for (int c = 0; c < 11; c++) begin
      run_case(C_MODE[c], C_IN[c], C_OUT[c]);
    end
    cmp_flag(1'b0);
    $display("test carry chain done");
    // unused bits drop, random contents
    @(posedge clk) #1 hour_mode_12 = 1'b0;
    i_host.frame(1'b1);
    for (int k = 0; k < 6; k++) begin
      rv = 8'(xs());
      i_host.wr(ADDR_MINUTES + 8'(k), rv);
      rd_exp(ADDR_MINUTES + 8'(k), rv & MSK[k]);
    end
    i_host.frame(1'b0);
    $display("test field masks done");
    // crystal stops: flag sets and cannot be cleared until it runs
    @(posedge clk) #1 osc_run = 1'b0;
    repeat (TSTOP + 100) @(posedge clk);
    #1 cmp_flag(1'b1);
    i_host.frame(1'b1);
    i_host.wr(ADDR_SECONDS, 8'h00);
    rd_exp(ADDR_SECONDS, 8'h80);
    i_host.frame(1'b0);
    osc_run = 1'b1;
    repeat (100) @(posedge clk);
    // running again, but the flag must wait for a clearing write
    #1 cmp_flag(1'b1);
    i_host.frame(1'b1);
    i_host.wr(ADDR_SECONDS, 8'h00);
    rd_exp(ADDR_SECONDS, 8'h00);
    i_host.frame(1'b0);
    cmp_flag(1'b0);
    $display("test oscillator stop done");
    repeat (2) @(posedge clk);
    if (exp_q.size() != 0) fail("reads missing");
    end_sim();
  end
endmodule : test_rtcc_time_date
